// ### src/hsb_defines.vh
// Register indices, reset values and field positions of the homing bank
`ifndef HSB_DEFINES_VH
`define HSB_DEFINES_VH
// Register indices; byte address is four times the index
`define HSB_IX_FAULT     16'h603F
`define HSB_IX_CMD       16'h6040
`define HSB_IX_STATE     16'h6041
`define HSB_IX_MODE      16'h6060
`define HSB_IX_MODE_RB   16'h6061
`define HSB_IX_CPOS      16'h6062
`define HSB_IX_MPOS      16'h6063
`define HSB_IX_UPOS      16'h6064
`define HSB_IX_FERR_WIN  16'h6065
`define HSB_IX_ARR_WIN   16'h6067
`define HSB_IX_ARR_TIME  16'h6068
`define HSB_IX_CVEL      16'h606B
`define HSB_IX_VEL       16'h606C
`define HSB_IX_ORG_OFS   16'h607C
`define HSB_IX_LIM_HI    16'h607D
`define HSB_IX_HM_METH   16'h6098
`define HSB_IX_DEC_SPD   16'h6099
`define HSB_IX_ACCEL     16'h609A
`define HSB_IX_LIM_LO    16'h6100
`define HSB_IX_SW_SPD    16'h6101
`define HSB_IX_IRQ_STAT  16'h6110
`define HSB_IX_IRQ_EN    16'h6111
`define HSB_IX_IRQ_CLR   16'h6112
`define HSB_IX_RETAIN    16'h6113
// Reset values
`define HSB_RST_ARR_WIN  32'h00000032
`define HSB_RST_LIM_HI   32'h7FFFFFFF
`define HSB_RST_LIM_LO   32'h80000000
`define HSB_RST_DEC_SPD  32'h0000C350
`define HSB_RST_SW_SPD   32'h00002710
`define HSB_RST_ACCEL    32'h000003E8
// Operating mode value that selects homing
`define HSB_MODE_HOMING  8'h06
// Command word bits
`define HSB_CW_HOME      4
`define HSB_CW_HALT      8
// Interrupt status bits
`define HSB_EV_DONE      0
`define HSB_EV_FAIL      1
`define HSB_EV_LIMIT     2
`define HSB_EV_WARN      3
`define HSB_EV_W         4
// Byte address bits below the word index
`define HSB_ADR_LSB      2
// Status word bit positions
`define HSB_SW_CAN_EN0   0
`define HSB_SW_CAN_EN1   1
`define HSB_SW_ENABLED   2
`define HSB_SW_CAN_EN3   3
`define HSB_SW_QSTOP_N   4
`define HSB_SW_CAN_EN5   5
`define HSB_SW_CAN_EN6   6
`define HSB_SW_WARN      7
`define HSB_SW_SPARE8    8
`define HSB_SW_REMOTE    9
`define HSB_SW_REACH     10
`define HSB_SW_LIMIT     11
`define HSB_SW_HM_CMP    12
`define HSB_SW_HM_ERR    13
`define HSB_SW_SPARE14   14
`define HSB_SW_HOMED     15
`endif

// ### src/hsb_bank.v
// Homing status word and object bank behind a Wishbone slave
`timescale 1ns/1ps
`include "hsb_defines.vh"
module hsb_bank #(
   parameter AW = 18
) (
   input  wire          core_clk,
   input  wire          sys_rst,
   // Wishbone slave
   input  wire          wb_cyc_i,
   input  wire          wb_stb_i,
   input  wire          wb_we_i,
   input  wire [AW-1:0] wb_adr_i,
   input  wire [3:0]    wb_sel_i,
   input  wire [31:0]   wb_dat_i,
   output reg  [31:0]   wb_dat_o,
   output reg           wb_ack_o,
   // Drive core state, same clock
   input  wire          servo_can_enable,
   input  wire          servo_enabled,
   input  wire          quick_stop_active,
   input  wire          warning_active,
   input  wire          remote_active,
   input  wire          target_reached,
   input  wire          velocity_zero,
   input  wire          homing_done,
   input  wire          homing_fail,
   input  wire          abs_encoder,
   input  wire          nv_homed,
   input  wire [15:0]   fault_code,
   input  wire [31:0]   cmd_pos,
   input  wire [31:0]   motor_pos,
   input  wire [31:0]   user_pos,
   input  wire [31:0]   cmd_vel,
   input  wire [31:0]   act_vel,
   // Configuration towards the drive core
   output wire          homing_run,
   output reg           nv_homed_store,
   output reg  [15:0]   command_word,
   output reg  [7:0]    operating_mode_select,
   output reg  [7:0]    homing_method_select,
   output reg  [31:0]   following_error_window,
   output reg  [31:0]   arrival_window,
   output reg  [15:0]   arrival_window_time,
   output reg  [31:0]   origin_offset,
   output reg  [31:0]   soft_limit_upper,
   output reg  [31:0]   soft_limit_lower,
   output reg  [31:0]   decel_point_search_speed,
   output reg  [31:0]   switch_search_speed,
   output reg  [31:0]   origin_search_accel,
   output wire [15:0]   drive_state_word,
   output wire          irq
);

   // Byte-lane merge of write data into a register
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  sel;
      integer      i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i])
               merge[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
   endfunction

   // Signed compare of two words: a at or above b
   function at_or_above;
      input [31:0] a;
      input [31:0] b;
      begin
         at_or_above = ($signed(a) >= $signed(b));
      end
   endfunction

   // Bus decode
   wire [15:0] idx;
   wire        acc;
   wire        wr;
   // Result flags, edge history and interrupt state
   reg         homing_cmp;
   reg         homing_err;
   reg         homed_flag;
   reg         homed_retain;
   reg         load_pending;
   reg         home_bit_q;
   reg         limit_q;
   reg         warn_q;
   reg  [3:0]  irq_stat;
   reg  [3:0]  irq_en;
   reg  [31:0] next_rdata;
   wire        limit_hit;
   wire        run_start;
   wire [3:0]  ev;
   wire [3:0]  clr_bits;
   // Qualified homing results and merged narrow words
   wire        done_seen;
   wire        fail_seen;
   wire [31:0] cmd_merged;
   wire [31:0] art_merged;
   reg  [7:0]  mode_shown;

   // Word index from the byte address; the two low bits pick a byte
   // in the word and are covered by the lane selects instead
   assign idx = wb_adr_i[AW-1:`HSB_ADR_LSB];
   assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr  = acc & wb_we_i;

   // Position at or beyond either software limit; sitting exactly
   // on a limit counts as reached, so a move that stops there shows it
   assign limit_hit =
      at_or_above(user_pos, soft_limit_upper) |
      at_or_above(soft_limit_lower, user_pos);

   // Homing runs only in homing mode with the home bit held
   assign homing_run = command_word[`HSB_CW_HOME] &
      (operating_mode_select == `HSB_MODE_HOMING);
   assign run_start = homing_run & ~home_bit_q;

   // Readiness copies; the drive core decides when enabling is possible
   assign drive_state_word[`HSB_SW_CAN_EN0] = servo_can_enable;
   assign drive_state_word[`HSB_SW_CAN_EN1] = servo_can_enable;
   assign drive_state_word[`HSB_SW_CAN_EN3] = servo_can_enable;
   assign drive_state_word[`HSB_SW_CAN_EN5] = servo_can_enable;
   assign drive_state_word[`HSB_SW_CAN_EN6] = servo_can_enable;

   // Enable, quick stop (shown inverted) and warning levels
   assign drive_state_word[`HSB_SW_ENABLED] = servo_enabled;
   assign drive_state_word[`HSB_SW_QSTOP_N] = ~quick_stop_active;
   assign drive_state_word[`HSB_SW_WARN]    = warning_active;
   assign drive_state_word[`HSB_SW_SPARE8]  = 1'b0;

   // Remote and reach; halt turns reach into a zero-speed report
   assign drive_state_word[`HSB_SW_REMOTE]  = remote_active;
   assign drive_state_word[`HSB_SW_REACH]   = command_word[`HSB_CW_HALT] ?
      velocity_zero : target_reached;

   // Limit and homing results
   assign drive_state_word[`HSB_SW_LIMIT]   = limit_hit;
   assign drive_state_word[`HSB_SW_HM_CMP]  = homing_cmp;
   assign drive_state_word[`HSB_SW_HM_ERR]  = homing_err;
   assign drive_state_word[`HSB_SW_SPARE14] = 1'b0;
   assign drive_state_word[`HSB_SW_HOMED]   = homed_flag;

   // Results count only inside a run and not in its first cycle, so
   // a level left over from the last run cannot mark the new one
   assign done_seen = homing_done & homing_run & ~run_start;
   assign fail_seen = homing_fail & homing_run & ~run_start;

   // Interrupt events and the write-only clear
   assign ev[`HSB_EV_DONE]  = done_seen;
   assign ev[`HSB_EV_FAIL]  = fail_seen;
   assign ev[`HSB_EV_LIMIT] = limit_hit & ~limit_q;
   assign ev[`HSB_EV_WARN]  = warning_active & ~warn_q;
   assign clr_bits = (wr && idx == `HSB_IX_IRQ_CLR) ?
      wb_dat_i[`HSB_EV_W-1:0] : 4'h0;
   assign irq = |(irq_stat & irq_en);

   // 16-bit objects merged as full words; the upper lanes are dropped
   assign cmd_merged =
      merge({16'h0000, command_word}, wb_dat_i, wb_sel_i);
   assign art_merged =
      merge({16'h0000, arrival_window_time}, wb_dat_i, wb_sel_i);

   // Edge history for the event detectors; a level already high at
   // reset release counts as a new event
   always @(posedge core_clk) begin
      if (sys_rst) begin
         home_bit_q <= 1'b0;
         limit_q    <= 1'b0;
         warn_q     <= 1'b0;
      end else begin
         home_bit_q <= homing_run;
         limit_q    <= limit_hit;
         warn_q     <= warning_active;
      end
   end

   // Sticky interrupt status; a new event beats a clear, so an event
   // in the cycle of the clear is never lost
   always @(posedge core_clk) begin
      if (sys_rst)
         irq_stat <= 4'h0;
      else
         irq_stat <= (irq_stat & ~clr_bits) | ev;
   end

   // Homing result flags; the start of a run wins, so an old result
   // is never reported against the new run
   always @(posedge core_clk) begin
      if (sys_rst) begin
         homing_cmp <= 1'b0;
         homing_err <= 1'b0;
      end else if (run_start) begin
         homing_cmp <= 1'b0;
         homing_err <= 1'b0;
      end else begin
         if (done_seen)
            homing_cmp <= 1'b1;
         if (fail_seen)
            homing_err <= 1'b1;
      end
   end

   // Homed-once flag; restored from storage just after reset since a
   // sync reset may only load a constant. Storage is only written
   // with retention set, and retention itself resets, so the restore
   // must not wait for it or the flag could never survive a reset
   always @(posedge core_clk) begin
      if (sys_rst) begin
         homed_flag   <= 1'b0;
         load_pending <= 1'b1;
      end else begin
         load_pending <= 1'b0;
         if (load_pending)
            homed_flag <= nv_homed & abs_encoder;
         else if (done_seen)
            homed_flag <= 1'b1;
      end
   end

   // Level asking the keeper of nonvolatile state to save the flag;
   // it drops in reset, and the keeper holds what it last stored
   always @(posedge core_clk) begin
      if (sys_rst)
         nv_homed_store <= 1'b0;
      else
         nv_homed_store <= homed_flag & homed_retain & abs_encoder;
   end

   // Mode display follows the selected mode one edge later, so it
   // shows the mode in effect rather than a write in flight
   always @(posedge core_clk) begin
      if (sys_rst)
         mode_shown <= 8'h00;
      else
         mode_shown <= operating_mode_select;
   end

   // Writable objects; the 8-bit objects take lane 0 only, and
   // writes to read-only or unmapped words are dropped silently
   always @(posedge core_clk) begin
      if (sys_rst) begin
         command_word             <= 16'h0000;
         operating_mode_select    <= 8'h00;
         homing_method_select     <= 8'h00;
         following_error_window   <= 32'h00000000;
         arrival_window           <= `HSB_RST_ARR_WIN;
         arrival_window_time      <= 16'h0000;
         origin_offset            <= 32'h00000000;
         soft_limit_upper         <= `HSB_RST_LIM_HI;
         soft_limit_lower         <= `HSB_RST_LIM_LO;
         decel_point_search_speed <= `HSB_RST_DEC_SPD;
         switch_search_speed      <= `HSB_RST_SW_SPD;
         origin_search_accel      <= `HSB_RST_ACCEL;
         irq_en                   <= 4'h0;
         homed_retain             <= 1'b0;
      end else if (wr) begin
         case (idx)
            `HSB_IX_CMD:
               command_word <= cmd_merged[15:0];
            `HSB_IX_MODE:
               if (wb_sel_i[0])
                  operating_mode_select <= wb_dat_i[7:0];
            `HSB_IX_HM_METH:
               if (wb_sel_i[0])
                  homing_method_select <= wb_dat_i[7:0];
            `HSB_IX_FERR_WIN:
               following_error_window <=
                  merge(following_error_window, wb_dat_i, wb_sel_i);
            `HSB_IX_ARR_WIN:
               arrival_window <=
                  merge(arrival_window, wb_dat_i, wb_sel_i);
            `HSB_IX_ARR_TIME:
               arrival_window_time <= art_merged[15:0];
            `HSB_IX_ORG_OFS:
               origin_offset <=
                  merge(origin_offset, wb_dat_i, wb_sel_i);
            `HSB_IX_LIM_HI:
               soft_limit_upper <=
                  merge(soft_limit_upper, wb_dat_i, wb_sel_i);
            `HSB_IX_LIM_LO:
               soft_limit_lower <=
                  merge(soft_limit_lower, wb_dat_i, wb_sel_i);
            `HSB_IX_DEC_SPD:
               decel_point_search_speed <= merge(
                  decel_point_search_speed, wb_dat_i, wb_sel_i);
            `HSB_IX_SW_SPD:
               switch_search_speed <=
                  merge(switch_search_speed, wb_dat_i, wb_sel_i);
            `HSB_IX_ACCEL:
               origin_search_accel <=
                  merge(origin_search_accel, wb_dat_i, wb_sel_i);
            `HSB_IX_IRQ_EN:
               if (wb_sel_i[0])
                  irq_en <= wb_dat_i[`HSB_EV_W-1:0];
            `HSB_IX_RETAIN:
               if (wb_sel_i[0])
                  homed_retain <= wb_dat_i[0];
            default: ;
         endcase
      end
   end

   // Read mux; unmapped and write-only words read zero, so software
   // can probe the map without side effects
   always @* begin
      next_rdata = 32'h00000000;
      case (idx)
         `HSB_IX_FAULT:     next_rdata[15:0] = fault_code;
         `HSB_IX_CMD:       next_rdata[15:0] = command_word;
         `HSB_IX_STATE:     next_rdata[15:0] = drive_state_word;
         `HSB_IX_MODE:      next_rdata[7:0]  = operating_mode_select;
         `HSB_IX_MODE_RB:   next_rdata[7:0]  = mode_shown;
         `HSB_IX_CPOS:      next_rdata = cmd_pos;
         `HSB_IX_MPOS:      next_rdata = motor_pos;
         `HSB_IX_UPOS:      next_rdata = user_pos;
         `HSB_IX_FERR_WIN:  next_rdata = following_error_window;
         `HSB_IX_ARR_WIN:   next_rdata = arrival_window;
         `HSB_IX_ARR_TIME:  next_rdata[15:0] = arrival_window_time;
         `HSB_IX_CVEL:      next_rdata = cmd_vel;
         `HSB_IX_VEL:       next_rdata = act_vel;
         `HSB_IX_ORG_OFS:   next_rdata = origin_offset;
         `HSB_IX_LIM_HI:    next_rdata = soft_limit_upper;
         `HSB_IX_LIM_LO:    next_rdata = soft_limit_lower;
         `HSB_IX_HM_METH:   next_rdata[7:0] = homing_method_select;
         `HSB_IX_DEC_SPD:   next_rdata = decel_point_search_speed;
         `HSB_IX_SW_SPD:    next_rdata = switch_search_speed;
         `HSB_IX_ACCEL:     next_rdata = origin_search_accel;
         `HSB_IX_IRQ_STAT:  next_rdata[3:0] = irq_stat;
         `HSB_IX_IRQ_EN:    next_rdata[3:0] = irq_en;
         `HSB_IX_RETAIN:    next_rdata[0] = homed_retain;
         default:           next_rdata = 32'h00000000;
      endcase
   end

   // One-cycle acknowledge; every address is answered. Ack low in
   // the taking term keeps a held request from being taken twice,
   // at the cost of one idle cycle between transfers
   always @(posedge core_clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= acc;
         if (acc & ~wb_we_i)
            wb_dat_o <= next_rdata;
      end
   end

endmodule // hsb_bank

// ### tb/hsb_properties.sv
// Port checker for the homing status object bank
`timescale 1ns/1ps
module hsb_checker (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        servo_can_enable,
   input wire logic        servo_enabled,
   input wire logic        quick_stop_active,
   input wire logic        warning_active,
   input wire logic        remote_active,
   input wire logic        target_reached,
   input wire logic        velocity_zero,
   input wire logic [31:0] user_pos,
   input wire logic [15:0] command_word,
   input wire logic [7:0]  operating_mode_select,
   input wire logic [31:0] soft_limit_upper,
   input wire logic [31:0] soft_limit_lower,
   input wire logic [15:0] drive_state_word,
   input wire logic        homing_run
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Signed compare; limits equal to position count as reached
   logic at_lim;
   assign at_lim = ($signed(user_pos) >= $signed(soft_limit_upper)) ||
                   ($signed(user_pos) <= $signed(soft_limit_lower));
   // Status bits follow the drive core levels
   ready_bits_a: assert property ({drive_state_word[6:5], drive_state_word[3],
      drive_state_word[1:0]} == {5{servo_can_enable}})
      else $error("ready bits wrong");
   enabled_bit_a: assert property (drive_state_word[2] == servo_enabled)
      else $error("enabled bit wrong");
   quick_stop_a: assert property (drive_state_word[4] != quick_stop_active)
      else $error("quick stop bit wrong");
   warning_bit_a: assert property (drive_state_word[7] == warning_active)
      else $error("warning bit wrong");
   remote_bit_a: assert property (drive_state_word[9] == remote_active)
      else $error("remote bit wrong");
   reach_bit_a: assert property (drive_state_word[10] ==
      (command_word[8] ? velocity_zero : target_reached))
      else $error("reach bit wrong");
   limit_bit_a: assert property (drive_state_word[11] == at_lim)
      else $error("limit bit wrong");
   home_run_a: assert property (homing_run ==
      (command_word[4] && operating_mode_select == 8'h06))
      else $error("homing run wrong");
   home_start_a: assert property ($rose(homing_run) |=>
      !drive_state_word[12] && !drive_state_word[13])
      else $error("stale homing result");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
endmodule // hsb_checker
bind hsb_bank hsb_checker hsb_checker_i (.*);

// ### tb/hsb_host_model.sv
// Wishbone master standing in for the host motion controller
`timescale 1ns/1ps
module hsb_host_model (
   input  wire logic        core_clk,
   output logic             wb_cyc_i,
   output logic             wb_stb_i,
   output logic             wb_we_i,
   output logic [17:0]      wb_adr_i,
   output logic [3:0]       wb_sel_i,
   output logic [31:0]      wb_dat_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o
);
   // Idle bus from time zero
   initial begin
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_adr_i = 18'h0;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
   end
   // One classic cycle; request held until ack is sampled high
   task automatic xfer(input logic w, input logic [15:0] ix,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= {ix, 2'b00};
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do @(posedge core_clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_dat_i <= ~d; // Released data must not look valid
   endtask
endmodule // hsb_host_model

// ### tb/tb.sv
// Self-checking bench for the homing status object bank
`timescale 1ns/1ps
`include "hsb_defines.vh"
module tb;
   logic core_clk = 0, sys_rst = 1, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [17:0] wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, soft_limit_upper, user_pos = 0;
   logic [15:0] fault_code = 16'h1234, command_word, drive_state_word;
   logic servo_can_enable = 0, servo_enabled = 0, quick_stop_active = 0;
   logic warning_active = 0, remote_active = 0, target_reached = 0;
   logic velocity_zero = 0, homing_done = 0, homing_fail = 0;
   logic abs_encoder = 0, nv_homed = 0, homing_run, nv_homed_store, irq;
   int   error_cnt = 0, tests_run = 0, cyc_cnt = 0;
   hsb_bank hsb_bank_i (.*, .cmd_pos(32'h0),
      .motor_pos(32'h0), .cmd_vel(32'h0), .act_vel(32'h0),
      .operating_mode_select(), .homing_method_select(),
      .following_error_window(), .arrival_window(), .arrival_window_time(),
      .origin_offset(), .soft_limit_lower(), .decel_point_search_speed(),
      .switch_search_speed(), .origin_search_accel());
   hsb_host_model hsb_host_model_i (.*);
   // Nonvolatile keeper: once asked to save, the flag stays stored
   always @(posedge core_clk) begin
      if (nv_homed_store) begin
         nv_homed <= 1'b1;
      end
   end
   // 20 MHz clock
   always #25 core_clk = ~core_clk;
   // Hang guard, far above the expected few hundred cycles
   always @(posedge core_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 3000) begin
         error_cnt++;
         report_and_stop;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [15:0] ix, input logic [31:0] m, e);
      logic [31:0] q;
      hsb_host_model_i.xfer(1'b0, ix, 32'h0, q);
      chk(q & m, e);
   endtask
   task automatic wr(input logic [15:0] ix, input logic [31:0] d);
      logic [31:0] q;
      hsb_host_model_i.xfer(1'b1, ix, d, q);
   endtask
   task automatic t_defaults;
      rd(`HSB_IX_LIM_HI, '1, `HSB_RST_LIM_HI);
      rd(`HSB_IX_LIM_LO, '1, `HSB_RST_LIM_LO);
      rd(`HSB_IX_DEC_SPD, '1, `HSB_RST_DEC_SPD);
      rd(`HSB_IX_SW_SPD, '1, `HSB_RST_SW_SPD);
      rd(`HSB_IX_ARR_WIN, '1, `HSB_RST_ARR_WIN);
      rd(`HSB_IX_ACCEL, '1, `HSB_RST_ACCEL);
      wr(`HSB_IX_FAULT, 32'h0);
      rd(`HSB_IX_FAULT, '1, 32'h00001234);
      rd(16'h7000, '1, 32'h0);
      $display("test defaults done");
   endtask
   task automatic t_status;
      @(posedge core_clk);
      {servo_can_enable, quick_stop_active} <= 2'h3;
      {warning_active, target_reached} <= 2'h3;
      rd(`HSB_IX_STATE, 32'hFFFF, 32'h04EB);
      @(posedge core_clk);
      {servo_can_enable, quick_stop_active, warning_active} <= 3'h0;
      {servo_enabled, remote_active, velocity_zero} <= 3'h7;
      target_reached <= 1'b0;
      wr(`HSB_IX_CMD, 32'h0100);
      rd(`HSB_IX_STATE, 32'hFFFF, 32'h0614);
      wr(`HSB_IX_CMD, 32'h0);
      rd(`HSB_IX_STATE, 32'h0400, 32'h0);
      $display("test status done");
   endtask
   task automatic t_limit;
      wr(`HSB_IX_LIM_HI, 32'h1000);
      chk(soft_limit_upper, 32'h1000);
      wr(`HSB_IX_IRQ_CLR, 32'hF);
      wr(`HSB_IX_IRQ_EN, 32'h4);
      user_pos <= 32'h0FFF;
      rd(`HSB_IX_STATE, 32'h0800, 32'h0);
      user_pos <= 32'h1000;
      rd(`HSB_IX_STATE, 32'h0800, 32'h0800);
      rd(`HSB_IX_IRQ_STAT, 32'h4, 32'h4);
      chk(irq, 1'b1);
      wr(`HSB_IX_IRQ_EN, 32'h0);
      chk(irq, 1'b0);
      wr(`HSB_IX_IRQ_EN, 32'h4);
      wr(`HSB_IX_IRQ_CLR, 32'h4);
      chk(irq, 1'b0);
      rd(`HSB_IX_IRQ_STAT, 32'h4, 32'h0);
      user_pos <= 32'h80000000;
      rd(`HSB_IX_STATE, 32'h0800, 32'h0800);
      user_pos <= 32'h0;
      $display("test limit done");
   endtask
   task automatic t_homing;
      wr(`HSB_IX_IRQ_CLR, 32'hF);
      wr(`HSB_IX_IRQ_EN, 32'h3);
      wr(`HSB_IX_RETAIN, 32'h1);
      abs_encoder <= 1'b1;
      wr(`HSB_IX_MODE, 32'h6);
      rd(`HSB_IX_MODE_RB, 32'hFF, 32'h6);
      wr(`HSB_IX_CMD, 32'h10);
      chk(homing_run, 1'b1);
      homing_done <= 1'b1;
      @(posedge core_clk) homing_done <= 1'b0;
      rd(`HSB_IX_STATE, 32'hB000, 32'h9000);
      chk(irq, 1'b1);
      chk(nv_homed_store, 1'b1);
      wr(`HSB_IX_IRQ_CLR, 32'h1);
      chk(irq, 1'b0);
      wr(`HSB_IX_CMD, 32'h0);
      chk(homing_run, 1'b0);
      wr(`HSB_IX_CMD, 32'h10);
      rd(`HSB_IX_STATE, 32'h3000, 32'h0);
      homing_fail <= 1'b1;
      @(posedge core_clk) homing_fail <= 1'b0;
      rd(`HSB_IX_STATE, 32'h2000, 32'h2000);
      chk(irq, 1'b1);
      $display("test homing done");
   endtask
   task automatic t_rw;
      wr(`HSB_IX_ORG_OFS, 32'hA5A50001);
      rd(`HSB_IX_ORG_OFS, '1, 32'hA5A50001);
      wr(`HSB_IX_FERR_WIN, 32'h00012345);
      rd(`HSB_IX_FERR_WIN, '1, 32'h00012345);
      wr(`HSB_IX_ARR_TIME, 32'hFFFF1234);
      rd(`HSB_IX_ARR_TIME, '1, 32'h00001234);
      wr(`HSB_IX_HM_METH, 32'h00000123);
      rd(`HSB_IX_HM_METH, '1, 32'h00000023);
      wr(`HSB_IX_CMD, 32'hABCD0100);
      rd(`HSB_IX_CMD, '1, 32'h00000100);
      chk(command_word, 32'h00000100);
      wr(`HSB_IX_DEC_SPD, 32'h00001388);
      rd(`HSB_IX_DEC_SPD, '1, 32'h00001388);
      wr(`HSB_IX_SW_SPD, 32'h000007D0);
      rd(`HSB_IX_SW_SPD, '1, 32'h000007D0);
      wr(`HSB_IX_CMD, 32'h0);
      $display("test rw done");
   endtask
   task automatic t_retain;
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(`HSB_IX_STATE, 32'h8000, 32'h8000);
      rd(`HSB_IX_RETAIN, 32'h1, 32'h0);
      rd(`HSB_IX_LIM_HI, '1, `HSB_RST_LIM_HI);
      chk(homing_run, 1'b0);
      chk(irq, 1'b0);
      abs_encoder <= 1'b0;
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(`HSB_IX_STATE, 32'h8000, 32'h0);
      $display("test retain done");
   endtask
   task report_and_stop;
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Reset for 20 cycles, then the scenarios in turn
   initial begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_defaults;
      t_rw;
      t_status;
      t_limit;
      t_homing;
      t_retain;
      report_and_stop;
   end
endmodule // tb
